// ==== common/routing_regs_params.svh ====
`ifndef ROUTING_REGS_PARAMS_SVH
`define ROUTING_REGS_PARAMS_SVH

// byte offsets on the register bus (printed offsets are register indices)
`define IDX_REVISION     8'h01
`define IDX_MCLK_ROUTE   8'h02
`define IDX_SUBCLK_ROUTE 8'h03
`define IDX_TX_CTL_A     8'h04
`define IDX_TX_CTL_B     8'h05
`define IDX_BOARD_CMD    8'h06
`define IDX_ADDR_SEL     8'h07

// reset values
`define RST_MCLK_ROUTE   8'h01
`define RST_SUBCLK_ROUTE 8'h00
`define RST_TX_CTL_A     8'h00
`define RST_TX_CTL_B     8'h03
`define RST_ADDR_SEL     2'h0

// writable bit masks (reserved bits read as zero)
`define MASK_MCLK_ROUTE  8'h71
`define MASK_SUBCLK      8'hbf
`define MASK_TX_CTL_A    8'hff
`define MASK_TX_CTL_B    8'h03

// field positions
`define BIT_OUT2_MCLK    6
`define BIT_OUT1_MCLK    5
`define BIT_AUX_MCLK     4
`define BIT_RX_RST       0
`define BIT_MUX_HDR      7
`define BIT_TX_RST       1
`define BIT_AUDIO        0

// revision code value, arbitrary
`define REVISION_VALUE   8'h10

// length of the self reset pulse in clock cycles
`define SELF_RST_CYCLES  4'h8

`endif

// ==== common/routing_regs_pkg.sv ====
package routing_regs_pkg;
    // direction code of one serial port clock buffer
    typedef enum logic [1:0] {
        DIR_HDR_DRIVES = 2'h0,
        DIR_RX_DRIVES  = 2'h1,
        DIR_RSV_2      = 2'h2,
        DIR_RSV_3      = 2'h3
    } clk_dir_t;
endpackage

// ==== verilog/clock_dir_buffer.sv ====
`timescale 1ns/100ps
`include "routing_regs_params.svh"

// one serial port direction buffer: frame and bit clock pass one way
module clock_dir_buffer
(
    input  wire logic [1:0] dir_code,   // direction field
    input  wire logic       hdr_lrck,   // header frame clock in
    input  wire logic       hdr_sclk,   // header bit clock in
    input  wire logic       rx_lrck,    // receiver frame clock in
    input  wire logic       rx_sclk,    // receiver bit clock in
    output logic            to_rx_oe,   // drive towards receiver
    output logic            to_hdr_oe,  // drive towards header
    output logic            rx_lrck_o,  // frame clock to receiver
    output logic            rx_sclk_o,  // bit clock to receiver
    output logic            hdr_lrck_o, // frame clock to header
    output logic            hdr_sclk_o  // bit clock to header
);
    // reserved codes drive nothing, so no two drivers fight on a wire
    always_comb
    begin
        to_rx_oe   = (dir_code == routing_regs_pkg::DIR_HDR_DRIVES);
        to_hdr_oe  = (dir_code == routing_regs_pkg::DIR_RX_DRIVES);
        rx_lrck_o  = hdr_lrck;
        rx_sclk_o  = hdr_sclk;
        hdr_lrck_o = rx_lrck;
        hdr_sclk_o = rx_sclk;
    end
endmodule

// ==== verilog/routing_regs.sv ====
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/100ps
`include "routing_regs_params.svh"

module routing_regs
(
    input  wire logic       clk,            // 50 MHz
    input  wire logic       nrst,           // sync, active low
    input  wire logic       ce,             // clock enable
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [7:0] wb_adr_i,
    input  wire logic [0:0] wb_sel_i,
    input  wire logic [7:0] wb_dat_i,
    output logic      [7:0] wb_dat_o,
    output logic            wb_ack_o,
    input  wire logic       recovered_master_clock,
    input  wire logic       osc_mclk,       // on-board oscillator
    input  wire logic       rx_aux_mclk,    // receiver output pin
    output logic            out1_hdr_mclk,
    output logic            out2_hdr_mclk,
    input  wire logic [2:0] hdr_lrck_i,     // per port, header side
    input  wire logic [2:0] hdr_sclk_i,
    input  wire logic [2:0] rx_lrck_i,      // per port, receiver side
    input  wire logic [2:0] rx_sclk_i,
    output logic      [2:0] hdr_lrck_o,
    output logic      [2:0] hdr_sclk_o,
    output logic      [2:0] hdr_oe,         // drives header pins
    output logic      [2:0] rx_lrck_o,
    output logic      [2:0] rx_sclk_o,
    output logic      [2:0] rx_oe,          // drives receiver pins
    input  wire logic [1:0] out_lrck_i,     // receiver outputs 1, 2
    input  wire logic [1:0] out_sclk_i,
    output logic            mux_hdr_lrck,
    output logic            mux_hdr_sclk,
    output logic            receiver_reset_n,
    output logic            transmitter_reset_n,
    output logic            addr_select_hi,
    output logic            addr_select_lo,
    output logic            addr_select_top,
    output logic      [1:0] tx_clock_ratio,
    output logic            tx_validity_level,
    output logic            tx_user_level,
    output logic            tx_block_sync_level,
    output logic            tx_chanstat_level,
    output logic      [1:0] tx_input_format,
    output logic            tx_audio_flag_level
);
    logic [7:0] mclk_r;          // master clock routing
    logic [7:0] subclk_r;        // subclock routing
    logic [7:0] txa_r;           // transmitter control a
    logic [7:0] txb_r;           // transmitter control b
    logic [1:0] addr_sel_r;      // receiver address select
    logic [3:0] self_rst_r;      // self reset countdown
    logic       soft_rst;        // restore of every register but the address select
    logic       wr_stb;          // write taken this cycle
    logic       rd_stb;          // access taken this cycle, read or write
    logic [7:0] rd_nxt;          // read mux
    logic       aux_mclk;        // chosen auxiliary clock
    logic [2:0] hdr_oe_c;
    logic [2:0] rx_oe_c;
    logic [2:0] hl_c;
    logic [2:0] hs_c;
    logic [2:0] rl_c;
    logic [2:0] rs_c;

    // register decode used for reads and writes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] i);
        hit = (a == i);
    endfunction

    // one access per handshake: ack rises once, falls next cycle
    assign wr_stb = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0];
    assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // while the countdown runs every register except the address select stays at its default
    assign soft_rst = (self_rst_r != 4'h0);

    // bus acknowledge, one cycle after the request
    always_ff @(posedge clk)
    begin
        if (!nrst)
            wb_ack_o <= 1'b0;
        else if (ce)
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end

    // self reset countdown: board command or address select change
    always_ff @(posedge clk)
    begin
        if (!nrst)
            self_rst_r <= 4'h0;
        else if (ce)
        begin
            if (wr_stb && hit(wb_adr_i, `IDX_BOARD_CMD) && wb_dat_i[0])
                self_rst_r <= `SELF_RST_CYCLES;
            else if (wr_stb && hit(wb_adr_i, `IDX_ADDR_SEL)
                     && (wb_dat_i[1:0] != addr_sel_r))
                self_rst_r <= `SELF_RST_CYCLES;
            else if (soft_rst)
                self_rst_r <= self_rst_r - 4'h1;
        end
    end

    // address select bits survive the self reset they caused,
    // otherwise the receiver would come back at its old address
    always_ff @(posedge clk)
    begin
        if (!nrst)
            addr_sel_r <= `RST_ADDR_SEL;
        else if (ce && wr_stb && hit(wb_adr_i, `IDX_ADDR_SEL))
            addr_sel_r <= wb_dat_i[1:0];
    end

    // master clock routing register
    always_ff @(posedge clk)
    begin
        if (!nrst || (ce && soft_rst))
            mclk_r <= `RST_MCLK_ROUTE;
        else if (ce && wr_stb && hit(wb_adr_i, `IDX_MCLK_ROUTE))
            mclk_r <= wb_dat_i & `MASK_MCLK_ROUTE;
    end

    // subclock routing register
    always_ff @(posedge clk)
    begin
        if (!nrst || (ce && soft_rst))
            subclk_r <= `RST_SUBCLK_ROUTE;
        else if (ce && wr_stb && hit(wb_adr_i, `IDX_SUBCLK_ROUTE))
            subclk_r <= wb_dat_i & `MASK_SUBCLK;
    end

    // transmitter control registers
    always_ff @(posedge clk)
    begin
        if (!nrst || (ce && soft_rst))
        begin
            txa_r <= `RST_TX_CTL_A;
            txb_r <= `RST_TX_CTL_B;
        end
        else if (ce && wr_stb)
        begin
            if (hit(wb_adr_i, `IDX_TX_CTL_A))
                txa_r <= wb_dat_i & `MASK_TX_CTL_A;
            if (hit(wb_adr_i, `IDX_TX_CTL_B))
                txb_r <= wb_dat_i & `MASK_TX_CTL_B;
        end
    end

    // read mux; unmapped offsets read zero and still ack
    always_comb
    begin
        rd_nxt = 8'h00;
        if (hit(wb_adr_i, `IDX_REVISION))
            rd_nxt = `REVISION_VALUE;
        else if (hit(wb_adr_i, `IDX_MCLK_ROUTE))
            rd_nxt = mclk_r;
        else if (hit(wb_adr_i, `IDX_SUBCLK_ROUTE))
            rd_nxt = subclk_r;
        else if (hit(wb_adr_i, `IDX_TX_CTL_A))
            rd_nxt = txa_r;
        else if (hit(wb_adr_i, `IDX_TX_CTL_B))
            rd_nxt = txb_r;
        else if (hit(wb_adr_i, `IDX_BOARD_CMD))
            rd_nxt = {7'h00, soft_rst};
        else if (hit(wb_adr_i, `IDX_ADDR_SEL))
            rd_nxt = {6'h00, addr_sel_r};
    end

    // read data register
    always_ff @(posedge clk)
    begin
        if (!nrst)
            wb_dat_o <= 8'h00;
        else if (ce && rd_stb)
            wb_dat_o <= rd_nxt;
    end

    // reset pins and address straps; receiver held in reset during
    // the self reset so both restart from defaults together
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            receiver_reset_n    <= 1'b0;
            transmitter_reset_n <= 1'b0;
            addr_select_hi      <= 1'b0;
            addr_select_lo      <= 1'b0;
            addr_select_top     <= 1'b0;
        end
        else if (ce)
        begin
            receiver_reset_n    <= mclk_r[`BIT_RX_RST]
                                   & ~soft_rst;
            transmitter_reset_n <= txb_r[`BIT_TX_RST];
            addr_select_hi      <= addr_sel_r[1];
            addr_select_lo      <= addr_sel_r[0];
            addr_select_top     <= 1'b0;
        end
    end

    // transmitter static levels
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            tx_clock_ratio      <= 2'h0;
            tx_validity_level   <= 1'b0;
            tx_user_level       <= 1'b0;
            tx_block_sync_level <= 1'b0;
            tx_chanstat_level   <= 1'b0;
            tx_input_format     <= 2'h0;
            tx_audio_flag_level <= 1'b1;
        end
        else if (ce)
        begin
            tx_clock_ratio      <= txa_r[7:6];
            tx_validity_level   <= txa_r[5];
            tx_user_level       <= txa_r[4];
            tx_block_sync_level <= txa_r[3];
            tx_chanstat_level   <= txa_r[2];
            tx_input_format     <= txa_r[1:0];
            tx_audio_flag_level <= txb_r[`BIT_AUDIO];
        end
    end

    // clock routing is retimed to clk: a limitation, only fit for
    // master clocks well below half of clk; a real board muxes them
    // in pure gates, traded here for registered outputs
    assign aux_mclk = mclk_r[`BIT_AUX_MCLK] ? rx_aux_mclk : osc_mclk;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            out1_hdr_mclk <= 1'b0;
            out2_hdr_mclk <= 1'b0;
            mux_hdr_lrck  <= 1'b0;
            mux_hdr_sclk  <= 1'b0;
        end
        else if (ce)
        begin
            out1_hdr_mclk <= mclk_r[`BIT_OUT1_MCLK] ? aux_mclk
                                                   : recovered_master_clock;
            out2_hdr_mclk <= mclk_r[`BIT_OUT2_MCLK] ? aux_mclk
                                                   : recovered_master_clock;
            // multiplexed header: zero takes output 2, one output 1
            mux_hdr_lrck  <= subclk_r[`BIT_MUX_HDR] ? out_lrck_i[0]
                                                   : out_lrck_i[1];
            mux_hdr_sclk  <= subclk_r[`BIT_MUX_HDR] ? out_sclk_i[0]
                                                   : out_sclk_i[1];
        end
    end

    // one direction buffer per port: 0 out1, 1 out2, 2 input
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : gen_dir
            clock_dir_buffer u_buf
            (
                .dir_code   (subclk_r[2*g+1:2*g]),
                .hdr_lrck   (hdr_lrck_i[g]),
                .hdr_sclk   (hdr_sclk_i[g]),
                .rx_lrck    (rx_lrck_i[g]),
                .rx_sclk    (rx_sclk_i[g]),
                .to_rx_oe   (rx_oe_c[g]),
                .to_hdr_oe  (hdr_oe_c[g]),
                .rx_lrck_o  (rl_c[g]),
                .rx_sclk_o  (rs_c[g]),
                .hdr_lrck_o (hl_c[g]),
                .hdr_sclk_o (hs_c[g])
            );
        end
    endgenerate

    // buffer outputs retimed so every top output is a flip-flop
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            hdr_oe     <= 3'h0;
            rx_oe      <= 3'h0;
            hdr_lrck_o <= 3'h0;
            hdr_sclk_o <= 3'h0;
            rx_lrck_o  <= 3'h0;
            rx_sclk_o  <= 3'h0;
        end
        else if (ce)
        begin
            hdr_oe     <= hdr_oe_c;
            rx_oe      <= rx_oe_c;
            hdr_lrck_o <= hl_c;
            hdr_sclk_o <= hs_c;
            rx_lrck_o  <= rl_c;
            rx_sclk_o  <= rs_c;
        end
    end
endmodule

// ==== tb/clock_source_model.sv ====
`timescale 1ns/100ps
// far side of the block: receiver chip, headers and oscillators
module clock_source_model
(
    input  wire logic [2:0] hdr_oe,
    input  wire logic       clk,
    output logic            recovered_master_clock,
    output logic            osc_mclk,
    output logic            rx_aux_mclk,
    output logic      [2:0] hdr_lrck_i,
    output logic      [2:0] hdr_sclk_i,
    output logic      [2:0] rx_lrck_i,
    output logic      [2:0] rx_sclk_i,
    output logic      [1:0] out_lrck_i,
    output logic      [1:0] out_sclk_i
);
    logic [3:0] ph_r = 4'h0; // free running phase

    // one counter gives every clock, so they stay in a known relation
    always_ff @(posedge clk)
    begin
        ph_r <= ph_r + 4'h1;
    end

    // distinct periods, so a wrong route is seen within five cycles
    assign osc_mclk = ph_r[0];
    assign rx_aux_mclk = ph_r[1];
    assign recovered_master_clock = ph_r[2];
    assign hdr_lrck_i = {3{ph_r[3]}};
    assign hdr_sclk_i = {3{~ph_r[0]}};
    // receiver drives a port only as master; floating pins toggle
    assign rx_lrck_i = (hdr_oe & {3{ph_r[1]}})
                       | (~hdr_oe & {3{ph_r[0]}});
    assign rx_sclk_i = {3{ph_r[2]}};
    assign out_lrck_i = {ph_r[1], ph_r[0]};
    assign out_sclk_i = ~{ph_r[1], ph_r[0]};
endmodule

// ==== tb/routing_regs_checker.sv ====
`timescale 1ns/100ps
`include "routing_regs_params.svh"
// bus handshake and pin checks, seen from the block's ports
module routing_regs_checker
(
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       ce,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [0:0] wb_sel_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic [7:0] wb_dat_o,
    input wire logic       wb_ack_o,
    input wire logic       receiver_reset_n,
    input wire logic       addr_select_top,
    input wire logic [2:0] hdr_oe,
    input wire logic [2:0] rx_oe,
    input wire logic [2:0] hdr_lrck_i,
    input wire logic [2:0] rx_lrck_i,
    input wire logic [2:0] hdr_lrck_o,
    input wire logic [2:0] rx_lrck_o
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // request taken on this edge
    sequence take_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
    endsequence
    // board reset command written
    sequence cmd_s;
        take_s ##0 wb_we_i && wb_sel_i[0] && wb_dat_i[0]
            && wb_adr_i == `IDX_BOARD_CMD;
    endsequence
    ack_answer_a: assert property (take_s |=> wb_ack_o)
        else $error("request not acknowledged");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
        else $error("ack without request");
    rev_read_a: assert property (take_s ##0 !wb_we_i
        && wb_adr_i == `IDX_REVISION |=> wb_dat_o == `REVISION_VALUE)
        else $error("revision code wrong");
    unmapped_read_a: assert property (take_s ##0 !wb_we_i
        && wb_adr_i > `IDX_ADDR_SEL |=> wb_dat_o == 8'h00)
        else $error("unmapped read not zero");
    oe_exclusive_a: assert property ((hdr_oe & rx_oe) == 3'h0)
        else $error("both buffer directions on");
    top_select_a: assert property (addr_select_top == 1'h0)
        else $error("top address select not low");
    cmd_reset_a: assert property (cmd_s ##1 ce [*2] |=> !receiver_reset_n)
        else $error("receiver not held in reset");
    // one flop behind the buffer; the sampled reset keeps the edge
    // that leaves reset from comparing against a cleared output
    clock_copy_a: assert property (nrst && ce |=>
        hdr_lrck_o == $past(rx_lrck_i) && rx_lrck_o == $past(hdr_lrck_i))
        else $error("serial clock not passed");
endmodule

bind routing_regs routing_regs_checker chk (.clk(clk), .nrst(nrst), .ce(ce),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .receiver_reset_n(receiver_reset_n), .addr_select_top(addr_select_top),
    .hdr_oe(hdr_oe), .rx_oe(rx_oe), .hdr_lrck_i(hdr_lrck_i),
    .rx_lrck_i(rx_lrck_i), .hdr_lrck_o(hdr_lrck_o), .rx_lrck_o(rx_lrck_o));

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
`include "routing_regs_params.svh"
module testbench;
    logic       clk, nrst, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i, wb_dat_i, wb_dat_o;
    logic [0:0] wb_sel_i;
    logic       recovered_master_clock, osc_mclk, rx_aux_mclk;
    logic       out1_hdr_mclk, out2_hdr_mclk, mux_hdr_lrck, mux_hdr_sclk;
    logic [2:0] hdr_lrck_i, hdr_sclk_i, rx_lrck_i, rx_sclk_i, hdr_oe, rx_oe;
    logic [2:0] hdr_lrck_o, hdr_sclk_o, rx_lrck_o, rx_sclk_o;
    logic [1:0] out_lrck_i, out_sclk_i, tx_clock_ratio, tx_input_format;
    logic       receiver_reset_n, transmitter_reset_n, addr_select_top;
    logic       addr_select_hi, addr_select_lo, tx_validity_level;
    logic       tx_user_level, tx_block_sync_level, tx_chanstat_level;
    logic       tx_audio_flag_level;
    logic [7:0] q;          // last read data
    int         error_cnt;  // mismatches
    int         n_compared; // comparisons made

    routing_regs dut (.*);
    clock_source_model src (.*);

    // 50 MHz clock
    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // the only place the run ends
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; waits for ack under a bound
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do
        begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        if (n >= 20)
        begin
            error_cnt++;
            $display("MISMATCH %0t no ack", $time);
            give_verdict;
        end
    endtask

    // let registered pin outputs settle
    task settle;
        repeat (2) @(negedge clk);
    endtask

    task t_defaults;
        wb(1'h0, `IDX_REVISION, 8'h00);
        chk(q, `REVISION_VALUE);
        wb(1'h0, `IDX_MCLK_ROUTE, 8'h00);
        chk(q, `RST_MCLK_ROUTE);
        wb(1'h0, `IDX_SUBCLK_ROUTE, 8'h00);
        chk(q, `RST_SUBCLK_ROUTE);
        wb(1'h0, `IDX_TX_CTL_A, 8'h00);
        chk(q, `RST_TX_CTL_A);
        wb(1'h0, `IDX_TX_CTL_B, 8'h00);
        chk(q, `RST_TX_CTL_B);
        settle;
        chk(8'(receiver_reset_n), 8'h01);
        chk(8'(transmitter_reset_n), 8'h01);
        chk(8'(tx_audio_flag_level), 8'h01);
    endtask

    // every writable bit set, reserved bits left at their default;
    // read-only and unmapped offsets ignore writes
    task t_masks;
        logic [7:0] lv; // transmitter level pins packed as the register
        wb(1'h1, `IDX_MCLK_ROUTE, `MASK_MCLK_ROUTE);
        wb(1'h1, `IDX_SUBCLK_ROUTE, `MASK_SUBCLK);
        wb(1'h1, `IDX_TX_CTL_A, `MASK_TX_CTL_A);
        wb(1'h1, `IDX_TX_CTL_B, `MASK_TX_CTL_B);
        wb(1'h0, `IDX_MCLK_ROUTE, 8'h00);
        chk(q, `MASK_MCLK_ROUTE);
        wb(1'h0, `IDX_SUBCLK_ROUTE, 8'h00);
        chk(q, `MASK_SUBCLK);
        wb(1'h0, `IDX_TX_CTL_A, 8'h00);
        chk(q, 8'hff);
        wb(1'h0, `IDX_TX_CTL_B, 8'h00);
        chk(q, 8'h03);
        wb(1'h1, `IDX_REVISION, 8'h00);
        wb(1'h0, `IDX_REVISION, 8'h00);
        chk(q, `REVISION_VALUE);
        wb(1'h1, 8'h20, 8'h55);
        wb(1'h0, 8'h20, 8'h00);
        chk(q, 8'h00);
        wb(1'h1, `IDX_TX_CTL_A, 8'ha5);
        wb(1'h1, `IDX_TX_CTL_B, 8'h00);
        wb(1'h1, `IDX_MCLK_ROUTE, 8'h00);
        settle;
        lv = {tx_clock_ratio, tx_validity_level, tx_user_level,
              tx_block_sync_level, tx_chanstat_level, tx_input_format};
        chk(lv, 8'ha5);
        chk(8'(tx_audio_flag_level), 8'h00);
        chk(8'(transmitter_reset_n), 8'h00);
        chk(8'(receiver_reset_n), 8'h00);
    endtask

    // each master clock source through both header outputs
    task t_route;
        logic [7:0] v [3];
        logic       e;
        v = '{8'h71, 8'h61, 8'h01};
        for (int i = 0; i < 3; i++)
        begin
            wb(1'h1, `IDX_MCLK_ROUTE, v[i]);
            settle;
            for (int k = 0; k < 4; k++)
            begin
                e = (i == 0) ? rx_aux_mclk
                    : (i == 1) ? osc_mclk : recovered_master_clock;
                @(negedge clk);
                chk(8'(out1_hdr_mclk), 8'(e));
                chk(8'(out2_hdr_mclk), 8'(e));
            end
        end
    endtask

    // direction codes 00, 01 and reserved 10, each port taking two of them
    task t_dirs;
        logic       e;  // expected multiplexed frame clock
        logic       f;  // expected multiplexed bit clock
        logic [2:0] hs; // expected bit clocks towards the headers
        logic [2:0] rs; // expected bit clocks towards the receiver
        wb(1'h1, `IDX_SUBCLK_ROUTE, 8'h24);
        settle;
        chk({2'h0, hdr_oe, rx_oe}, 8'h11);
        // select clear: output 2 reaches the multiplexed header
        e = out_lrck_i[1];
        @(negedge clk);
        chk(8'(mux_hdr_lrck), 8'(e));
        wb(1'h1, `IDX_SUBCLK_ROUTE, 8'h92);
        settle;
        chk({2'h0, hdr_oe, rx_oe}, 8'h22);
        for (int k = 0; k < 4; k++)
        begin
            e = out_lrck_i[0];
            f = out_sclk_i[0];
            hs = rx_sclk_i;
            rs = hdr_sclk_i;
            @(negedge clk);
            chk(8'(mux_hdr_lrck), 8'(e));
            chk(8'(mux_hdr_sclk), 8'(f));
            chk(8'(hdr_sclk_o), 8'(hs));
            chk(8'(rx_sclk_o), 8'(rs));
        end
    endtask

    // board reset command, then an address select change, then the same value again
    task t_resets;
        wb(1'h1, `IDX_TX_CTL_A, 8'h5a);
        wb(1'h1, `IDX_BOARD_CMD, 8'h01);
        settle;
        chk(8'(receiver_reset_n), 8'h00);
        repeat (10) @(negedge clk);
        wb(1'h0, `IDX_TX_CTL_A, 8'h00);
        chk(q, `RST_TX_CTL_A);
        wb(1'h1, `IDX_TX_CTL_A, 8'h5a);
        wb(1'h1, `IDX_ADDR_SEL, 8'h02);
        settle;
        chk(8'(receiver_reset_n), 8'h00);
        chk({addr_select_top, addr_select_hi, addr_select_lo}, 8'h02);
        repeat (10) @(negedge clk);
        wb(1'h0, `IDX_TX_CTL_A, 8'h00);
        chk(q, `RST_TX_CTL_A);
        wb(1'h1, `IDX_TX_CTL_A, 8'h5a);
        wb(1'h1, `IDX_ADDR_SEL, 8'h02);
        settle;
        chk(8'(receiver_reset_n), 8'h01);
        wb(1'h0, `IDX_TX_CTL_A, 8'h00);
        chk(q, 8'h5a);
    endtask

    initial
    begin
        error_cnt = 0;
        n_compared = 0;
        nrst = 1'h0;
        ce = 1'h1;
        wb_cyc_i = 1'h0;
        wb_stb_i = 1'h0;
        wb_we_i = 1'h0;
        wb_adr_i = 8'h00;
        wb_dat_i = 8'h00;
        wb_sel_i = 1'h1;
        repeat (12) @(posedge clk);
        nrst <= 1'h1;
        t_defaults;
        t_masks;
        t_route;
        t_dirs;
        t_resets;
        @(posedge clk);
        nrst <= 1'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        t_defaults;
        give_verdict;
    end
endmodule
